// ===== rtl/adcs_pkg.sv
// Purpose: Shared constants for the converter sequencer.
// Assumes: Avalon word addressing, one register per 32-bit word.
// Notes:   Bus address equals the register index below.
package adcs_pkg;
   // -----------------------------------------------------------------
   // Register indices and reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] CLK_SEL_IDX  = 32'hffffee04;
   localparam logic [31:0] RES3_LO_IDX  = 32'hfffff306;
   localparam logic [31:0] RES3_HI_IDX  = 32'hfffff307;
   localparam logic [31:0] MODE_A_IDX   = 32'hfffff310;
   localparam logic [31:0] MODE_B_IDX   = 32'hfffff311;
   localparam logic [1:0]  CLK_CODE_RST = 2'h0;
   localparam logic [1:0]  CLK_CODE_RSV = 2'h3;
   localparam logic [4:0]  LOW_ONES     = 5'h1f;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int MA_EOC = 7;
   localparam int MA_BSY = 6;
   localparam int MA_ITM = 3;
   localparam int MA_RPT = 2;
   localparam int MA_SCN = 1;
   localparam int MA_STR = 0;
   localparam int MB_REF = 7;
   localparam int MB_IDL = 6;
   localparam int MB_TRG = 5;
   // -----------------------------------------------------------------
   // Conversion timing in conversion clocks
   // -----------------------------------------------------------------
   localparam int          RES_BITS     = 10;
   localparam logic [6:0]  CONV_LAST    = 7'd85;
   localparam logic [6:0]  SAMPLE_CLKS  = 7'd20;
   localparam logic [2:0]  BIT_LAST     = 3'd5;
   localparam logic [1:0]  QUAD_LAST    = 2'h3;
endpackage : adcs_pkg

// ===== rtl/adcs_prescale.sv
// Purpose: Conversion clock enable from the system clock.
// Assumes: Code 11 never reaches this module.
// Notes:   Emits one-cycle pulses at fsys/2, /4 or /8.
`timescale 1ns/1ps
`default_nettype none
module adcs_prescale (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [1:0] code_in,
   output logic            tick_out
);
   logic [2:0] cnt_q;

   // Terminal count per code; the period doubles with each code step.
   function automatic logic [2:0] last_count(input logic [1:0] c);
      case (c)
         2'h0:    last_count = 3'h1;
         2'h1:    last_count = 3'h3;
         default: last_count = 3'h7;
      endcase
   endfunction : last_count

   // Free counter; a code change restarts cleanly via >= compare.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_q <= 3'h0;
      end else if (cnt_q >= last_count(code_in)) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
      end
   end

   assign tick_out = (cnt_q == last_count(code_in));

   tick_gap_a : assert property (@(posedge clk_in) disable iff (rst_in)
      tick_out |=> !tick_out)
      else $error("Conversion clock pulses back to back.");
endmodule : adcs_prescale
`default_nettype wire

// ===== rtl/adcs_sar.sv
// Purpose: Successive-approximation step control for one channel.
// Assumes: Comparator outside reports input above trial level.
// Notes:   A start pulse aborts and restarts at sampling.
`timescale 1ns/1ps
`default_nettype none
module adcs_sar #(
   parameter int W = adcs_pkg::RES_BITS
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         tick_in,
   input  wire logic         start_in,
   input  wire logic         comp_in,
   output logic              sampling_out,
   output logic [W-1:0]      trial_out,
   output logic [W-1:0]      result_out,
   output logic              done_out
);
   logic          run_q;
   logic [6:0]    cnt_q;
   logic [2:0]    sub_q;
   logic [3:0]    step_q;
   logic [W-1:0]  res_q;
   logic [W-1:0]  bit_sel;

   assign bit_sel = (step_q < 4'(W)) ? (W'(1) << (W - 1 - step_q)) : '0;
   assign trial_out    = res_q | bit_sel;
   assign sampling_out = run_q && (cnt_q < adcs_pkg::SAMPLE_CLKS);
   assign result_out   = res_q;

   // Eighty-six conversion clocks: sample, ten bit trials, settle.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         run_q    <= 1'b0;
         cnt_q    <= 7'd0;
         sub_q    <= 3'd0;
         step_q   <= 4'd0;
         res_q    <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            run_q  <= 1'b1;
            cnt_q  <= 7'd0;
            sub_q  <= 3'd0;
            step_q <= 4'd0;
            res_q  <= '0;
         end else if (run_q && tick_in) begin
            cnt_q <= cnt_q + 7'd1;
            if (cnt_q == adcs_pkg::CONV_LAST) begin
               run_q    <= 1'b0;
               done_out <= 1'b1;
            end else if (cnt_q >= adcs_pkg::SAMPLE_CLKS &&
                         step_q < 4'(W)) begin
               sub_q <= (sub_q == adcs_pkg::BIT_LAST) ? 3'd0 : sub_q + 3'd1;
               if (sub_q == adcs_pkg::BIT_LAST) begin
                  if (comp_in) begin
                     res_q <= res_q | bit_sel;
                  end
                  step_q <= step_q + 4'd1;
               end
            end
         end
      end
   end
endmodule : adcs_sar
`default_nettype wire

// ===== rtl/adcs_top.sv
// Purpose: Converter sequencer with Avalon-MM register access.
// Assumes: All inputs synchronous to CLK_IN (40 MHz).
// Notes:   Only result slot 3 is held here; other slots live elsewhere.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Low result byte: bits 7-6, ones, flag.
// - Store flag sets on store, read clears.
// - Two-bit code picks fsys/2, /4, /8.
// - Ten-bit result over 1024 reference steps.
// - Reference bit drives switch; software waits 3 us.
// - Fixed mode converts the coded input.
// - Scan converts group base up to code.
// - Reset selects fixed mode, input zero.
// - Start bit or trigger fall starts; busy.
// - Start bit aborts and restarts conversion.
// - Trigger falls ignored while converting.
// - Single fixed: convert, flag, idle, interrupt.
// - Single scan: group once, flag, interrupt.
// - End flag clears when read.
// - Each channel takes 86 conversion clocks.
// - Fixed repeat: busy stays, interrupt each or four.
// - Clearing repeat stops after current conversion.
module adcs_top (
   input  wire logic        CLK_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic [31:0] AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   input  wire logic [3:0]  AVS_BYTEENABLE_IN,
   output logic [31:0]      AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   input  wire logic        TRIGGER_N_IN,
   input  wire logic        COMPARE_IN,
   output logic [2:0]       CHANNEL_OUT,
   output logic             SAMPLE_OUT,
   output logic [9:0]       TRIAL_LEVEL_OUT,
   output logic             REF_SWITCH_OUT,
   output logic             RUN_IN_IDLE_OUT,
   output logic             BUSY_OUT,
   output logic             DONE_IRQ_OUT
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   typedef enum logic {ST_IDLE, ST_CONV} adcs_state_type;

   adcs_state_type state_q;
   logic        ack_q;
   logic        cont_q;
   logic        start_scn;
   logic        start_rpt;
   logic        wr_acc;
   logic        rd_acc;
   logic [1:0]  clk_code_q;
   logic [1:0]  eff_code_q;
   logic        itm_q;
   logic        rpt_q;
   logic        scn_q;
   logic        ref_q;
   logic        idl_q;
   logic        trg_en_q;
   logic [2:0]  code_q;
   logic        eoc_q;
   logic        store3_q;
   logic [9:0]  res3_q;
   logic [2:0]  ch_q;
   logic [1:0]  quad_q;
   logic        trg_prev_q;
   logic        trg_fall;
   logic        sw_start;
   logic        start_req;
   logic        tick;
   logic        core_done;
   logic        core_start;
   logic        next_ch;
   logic        seq_end;
   logic        fixed_rpt;
   logic        store3;
   logic        irq;
   logic        rd_res;
   logic        rd_mode_a;
   logic [9:0]  core_res;
   logic [7:0]  rd_byte;

   // -----------------------------------------------------------------
   // Address decode helpers
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [31:0] a, input logic [31:0] i);
      hit = (a == i);
   endfunction : hit

   // First input of the group that a code selects in scan mode.
   function automatic logic [2:0] group_base(input logic [2:0] c);
      group_base = {c[2], 2'h0};
   endfunction : group_base

   // -----------------------------------------------------------------
   // Avalon slave: one wait state, then answer
   // -----------------------------------------------------------------
   // A wait state lets read data come straight from a flip-flop.
   assign wr_acc = ack_q && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
   assign rd_acc = ack_q && AVS_READ_IN;
   assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;

   // Acknowledge toggles high for one cycle per request.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
      end
   end

   assign rd_res    = rd_acc && (hit(AVS_ADDRESS_IN, adcs_pkg::RES3_LO_IDX)
                      || hit(AVS_ADDRESS_IN, adcs_pkg::RES3_HI_IDX));
   assign rd_mode_a = rd_acc && hit(AVS_ADDRESS_IN, adcs_pkg::MODE_A_IDX);

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rd_byte = 8'h00;
      if (hit(AVS_ADDRESS_IN, adcs_pkg::RES3_LO_IDX)) begin
         rd_byte = {res3_q[1:0], adcs_pkg::LOW_ONES, store3_q};
      end else if (hit(AVS_ADDRESS_IN, adcs_pkg::RES3_HI_IDX)) begin
         rd_byte = res3_q[9:2];
      end else if (hit(AVS_ADDRESS_IN, adcs_pkg::CLK_SEL_IDX)) begin
         rd_byte = {6'h00, clk_code_q};
      end else if (hit(AVS_ADDRESS_IN, adcs_pkg::MODE_A_IDX)) begin
         rd_byte = {eoc_q, state_q == ST_CONV, 2'h0, itm_q, rpt_q,
                    scn_q, 1'b0};
      end else if (hit(AVS_ADDRESS_IN, adcs_pkg::MODE_B_IDX)) begin
         rd_byte = {ref_q, idl_q, trg_en_q, 2'h0, code_q};
      end
   end

   // Read data register, loaded at the edge that ends the wait.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         AVS_READDATA_OUT <= 32'h0000_0000;
      end else if (AVS_READ_IN && !ack_q) begin
         AVS_READDATA_OUT <= {24'h00_0000, rd_byte};
      end
   end

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   // The effective divider ignores the reserved code, so the converter
   // never runs from an undefined rate.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         clk_code_q <= adcs_pkg::CLK_CODE_RST;
         eff_code_q <= adcs_pkg::CLK_CODE_RST;
      end else if (wr_acc && hit(AVS_ADDRESS_IN, adcs_pkg::CLK_SEL_IDX)) begin
         clk_code_q <= AVS_WRITEDATA_IN[1:0];
         if (AVS_WRITEDATA_IN[1:0] != adcs_pkg::CLK_CODE_RSV) begin
            eff_code_q <= AVS_WRITEDATA_IN[1:0];
         end
      end
   end

   // Mode fields are sampled live, so a cleared repeat takes effect at
   // the end of the conversion under way.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         itm_q <= 1'b0;
         rpt_q <= 1'b0;
         scn_q <= 1'b0;
      end else if (wr_acc && hit(AVS_ADDRESS_IN, adcs_pkg::MODE_A_IDX)) begin
         itm_q <= AVS_WRITEDATA_IN[adcs_pkg::MA_ITM];
         rpt_q <= AVS_WRITEDATA_IN[adcs_pkg::MA_RPT];
         scn_q <= AVS_WRITEDATA_IN[adcs_pkg::MA_SCN];
      end
   end

   // Second mode register: reference, idle run, trigger, channel code.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         ref_q    <= 1'b0;
         idl_q    <= 1'b0;
         trg_en_q <= 1'b0;
         code_q   <= 3'h0;
      end else if (wr_acc && hit(AVS_ADDRESS_IN, adcs_pkg::MODE_B_IDX)) begin
         ref_q    <= AVS_WRITEDATA_IN[adcs_pkg::MB_REF];
         idl_q    <= AVS_WRITEDATA_IN[adcs_pkg::MB_IDL];
         trg_en_q <= AVS_WRITEDATA_IN[adcs_pkg::MB_TRG];
         code_q   <= AVS_WRITEDATA_IN[2:0];
      end
   end

   assign REF_SWITCH_OUT  = ref_q;
   assign RUN_IN_IDLE_OUT = idl_q;

   // -----------------------------------------------------------------
   // Start sources
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         trg_prev_q <= 1'b1;
      end else begin
         trg_prev_q <= TRIGGER_N_IN;
      end
   end

   assign trg_fall = trg_prev_q && !TRIGGER_N_IN;
   assign sw_start = wr_acc && hit(AVS_ADDRESS_IN, adcs_pkg::MODE_A_IDX)
                     && AVS_WRITEDATA_IN[adcs_pkg::MA_STR];
   // A trigger edge during a conversion is dropped, not queued.
   assign start_req = sw_start ||
                      (trg_fall && trg_en_q && state_q == ST_IDLE);
   // A start write also sets the mode, so it selects with the new bits.
   assign start_scn = sw_start ? AVS_WRITEDATA_IN[adcs_pkg::MA_SCN] : scn_q;
   assign start_rpt = sw_start ? AVS_WRITEDATA_IN[adcs_pkg::MA_RPT] : rpt_q;

   // -----------------------------------------------------------------
   // Sequencing
   // -----------------------------------------------------------------
   assign fixed_rpt  = rpt_q && !scn_q;
   assign next_ch    = core_done && !start_req && scn_q && ch_q != code_q &&
                       !(cont_q && !rpt_q);
   assign seq_end    = core_done && !start_req && !next_ch;
   assign core_start = start_req || next_ch ||
                       (seq_end && rpt_q);
   assign store3     = core_done && (fixed_rpt ? quad_q == adcs_pkg::QUAD_LAST
                                               : ch_q[1:0] == 2'h3);
   // Fixed repeat with interval mode set interrupts on every fourth.
   assign irq = seq_end && !(fixed_rpt && itm_q &&
                             quad_q != adcs_pkg::QUAD_LAST);

   // Busy state, channel pointer and whether the run repeats; a cleared
   // repeat in a continuous scan ends after the conversion under way.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         state_q <= ST_IDLE;
         ch_q    <= 3'h0;
         cont_q  <= 1'b0;
      end else if (start_req) begin
         state_q <= ST_CONV;
         ch_q    <= start_scn ? group_base(code_q) : code_q;
         cont_q  <= start_rpt;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_IDLE;
            end
            ST_CONV: begin
               if (next_ch) begin
                  ch_q <= ch_q + 3'h1;
               end else if (seq_end) begin
                  ch_q <= scn_q ? group_base(code_q) : code_q;
                  if (!rpt_q) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Conversion counter for sequential slots in fixed repeat mode.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN || start_req) begin
         quad_q <= 2'h0;
      end else if (core_done) begin
         quad_q <= quad_q + 2'h1;
      end
   end

   // End flag: a new end wins over a clearing read in the same cycle.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         eoc_q <= 1'b0;
      end else if (seq_end) begin
         eoc_q <= 1'b1;
      end else if (rd_mode_a || rd_res) begin
         eoc_q <= 1'b0;
      end
   end

   // Slot three result and its store flag; a store beats a read.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         store3_q <= 1'b0;
         res3_q   <= 10'h000;
      end else if (store3) begin
         store3_q <= 1'b1;
         res3_q   <= core_res;
      end else if (rd_res) begin
         store3_q <= 1'b0;
      end
   end

   // Interrupt pulse register.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         DONE_IRQ_OUT <= 1'b0;
      end else begin
         DONE_IRQ_OUT <= irq;
      end
   end

   assign BUSY_OUT    = (state_q == ST_CONV);
   assign CHANNEL_OUT = ch_q;

   // -----------------------------------------------------------------
   // Prescaler and bit engine
   // -----------------------------------------------------------------
   adcs_prescale u_prescale (
      .clk_in   (CLK_IN),
      .rst_in   (SYS_RST_IN),
      .code_in  (eff_code_q),
      .tick_out (tick)
   );

   adcs_sar u_sar (
      .clk_in       (CLK_IN),
      .rst_in       (SYS_RST_IN),
      .tick_in      (tick),
      .start_in     (core_start),
      .comp_in      (COMPARE_IN),
      .sampling_out (SAMPLE_OUT),
      .trial_out    (TRIAL_LEVEL_OUT),
      .result_out   (core_res),
      .done_out     (core_done)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   low_ones_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (rd_acc && hit(AVS_ADDRESS_IN, adcs_pkg::RES3_LO_IDX))
      |-> AVS_READDATA_OUT[5:1] == adcs_pkg::LOW_ONES)
      else $error("Low result byte bits 5-1 not ones.");

   flag_clear_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (rd_res && !store3) |=> !store3_q)
      else $error("Store flag not cleared by result read.");

   flag_set_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      store3 |=> store3_q && res3_q == $past(core_res))
      else $error("Store flag or result not loaded.");

   rsv_code_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (wr_acc && hit(AVS_ADDRESS_IN, adcs_pkg::CLK_SEL_IDX) &&
       AVS_WRITEDATA_IN[1:0] == adcs_pkg::CLK_CODE_RSV)
      |=> $stable(eff_code_q))
      else $error("Reserved code changed the divider.");

   busy_start_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      start_req |=> BUSY_OUT ##[1:1000] (SAMPLE_OUT || !BUSY_OUT))
      else $error("Start did not set busy.");

   trig_ignore_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (trg_fall && trg_en_q && BUSY_OUT && !sw_start && !core_done)
      |=> !$rose(SAMPLE_OUT))
      else $error("Trigger edge accepted while busy.");

   end_flag_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      seq_end |=> eoc_q)
      else $error("End flag not set at sequence end.");

   single_stop_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (seq_end && !rpt_q) |=> !BUSY_OUT)
      else $error("Busy stayed set after single sequence.");

   cont_stop_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (core_done && cont_q && !rpt_q && !start_req) |=> !BUSY_OUT)
      else $error("Cleared repeat did not stop the run.");

   scan_step_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      next_ch |=> ch_q == $past(ch_q) + 3'h1)
      else $error("Scan did not advance one input.");

   fixed_ch_a : assert property (@(posedge CLK_IN)
      disable iff (SYS_RST_IN)
      (start_req && !start_scn) |=> CHANNEL_OUT == $past(code_q))
      else $error("Fixed mode selected wrong input.");
endmodule : adcs_top
`default_nettype wire

// ===== verif/tb_adcs_top.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Comparator modelled as input level at or above trial level.
// Notes:   Results are checked only through result slot 3.
`timescale 1ns/1ps
`default_nettype none
module tb_adcs_top;
   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   localparam logic [31:0] CK = adcs_pkg::CLK_SEL_IDX;
   localparam logic [31:0] RL = adcs_pkg::RES3_LO_IDX;
   localparam logic [31:0] RH = adcs_pkg::RES3_HI_IDX;
   localparam logic [31:0] MA = adcs_pkg::MODE_A_IDX;
   localparam logic [31:0] MB = adcs_pkg::MODE_B_IDX;
   logic        CLK_IN = 1'b0;
   logic        SYS_RST_IN, AVS_READ_IN, AVS_WRITE_IN;
   logic [31:0] AVS_ADDRESS_IN, AVS_WRITEDATA_IN, AVS_READDATA_OUT;
   logic [3:0]  AVS_BYTEENABLE_IN;
   logic        AVS_WAITREQUEST_OUT, TRIGGER_N_IN, COMPARE_IN;
   logic [2:0]  CHANNEL_OUT;
   logic        SAMPLE_OUT, REF_SWITCH_OUT, RUN_IN_IDLE_OUT;
   logic [9:0]  TRIAL_LEVEL_OUT;
   logic        BUSY_OUT, DONE_IRQ_OUT;
   int          fails = 0, tests_run = 0, seed = 32'h5afa, irqs = 0;
   logic [9:0]  vin = 10'h000;
   logic        samp_q = 1'b0;
   logic [2:0]  chq[$];

   // Free-running system clock, 25 ns period.
   always #12.5 CLK_IN = ~CLK_IN;

   adcs_top dut (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
      .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
      .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
      .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
      .AVS_READDATA_OUT(AVS_READDATA_OUT),
      .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
      .TRIGGER_N_IN(TRIGGER_N_IN), .COMPARE_IN(COMPARE_IN),
      .CHANNEL_OUT(CHANNEL_OUT), .SAMPLE_OUT(SAMPLE_OUT),
      .TRIAL_LEVEL_OUT(TRIAL_LEVEL_OUT), .REF_SWITCH_OUT(REF_SWITCH_OUT),
      .RUN_IN_IDLE_OUT(RUN_IN_IDLE_OUT), .BUSY_OUT(BUSY_OUT),
      .DONE_IRQ_OUT(DONE_IRQ_OUT));

   // Comparator model, sampling-start channel log and interrupt count.
   always @(posedge CLK_IN) begin
      COMPARE_IN <= (TRIAL_LEVEL_OUT <= vin);
      samp_q <= SAMPLE_OUT;
      if (SAMPLE_OUT === 1'b1 && samp_q === 1'b0) chq.push_back(CHANNEL_OUT);
      if (DONE_IRQ_OUT === 1'b1) irqs = irqs + 1;
   end

   // ----------------------------------------------------------------
   // Compare, bus and wait tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Cycle counts are bench values, so plain integers suffice here.
   task automatic rng(input int g, input int lo, input int hi);
      tests_run++;
      if (g < lo || g > hi) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
      end
   endtask : rng

   // Expected low result byte: two low bits, five ones, store flag.
   function automatic logic [31:0] lo_exp(input logic [9:0] v,
                                          input logic       f);
      lo_exp = {24'h00_0000, v[1:0], 5'h1f, f};
   endfunction : lo_exp

   // One Avalon transfer; held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge CLK_IN);
      AVS_ADDRESS_IN <= a;
      AVS_WRITE_IN <= w;
      AVS_READ_IN <= ~w;
      AVS_WRITEDATA_IN <= {24'h0, d};
      n = 0;
      do begin
         @(posedge CLK_IN);
         n++;
      end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
      q = AVS_READDATA_OUT;
      AVS_READ_IN <= 1'b0;
      AVS_WRITE_IN <= 1'b0;
      rng(n, 1, 49);
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic wait_irq(input int max, output int n);
      n = 0;
      do begin
         @(posedge CLK_IN);
         n++;
      end while (DONE_IRQ_OUT !== 1'b1 && n < max);
   endtask : wait_irq

   task automatic print_verdict;
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // Watchdog sized well above the whole sequence.
   initial begin
      repeat (40000) @(posedge CLK_IN);
      fails++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q, r;
      int n, dv, k;
      logic [7:0] md;
      SYS_RST_IN = 1'b1;
      AVS_READ_IN = 1'b0;
      AVS_WRITE_IN = 1'b0;
      AVS_ADDRESS_IN = 32'h0;
      AVS_WRITEDATA_IN = 32'h0;
      AVS_BYTEENABLE_IN = 4'hf;
      TRIGGER_N_IN = 1'b1;
      repeat (16) @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      bus(1'b0, CK, 8'h00, q); chk(q, 32'h0);
      bus(1'b0, MB, 8'h00, q); chk(q, 32'h0);
      chk(CHANNEL_OUT, 32'h0);
      bus(1'b0, RL, 8'h00, q); chk(q & 32'h3f, 32'h3e);
      bus(1'b0, 32'hfffff308, 8'h00, q); chk(q, 32'h0);
      wr(MB, 8'hc3); @(posedge CLK_IN); chk(REF_SWITCH_OUT, 32'h1);
      chk(RUN_IN_IDLE_OUT, 32'h1);
      bus(1'b0, MB, 8'h00, q); chk(q, 32'hc3);
      // Software owes the reference 3 us to settle: 120 clocks here.
      repeat (120) @(posedge CLK_IN);
      // Fixed single on input 3 for each divider code, reserved last.
      for (int c = 0; c < 4; c++) begin
         wr(CK, 8'(c)); bus(1'b0, CK, 8'h00, q); chk(q, c);
         dv = (c == 3) ? 8 : (2 << c);
         r = $random(seed);
         vin = (c == 0) ? 10'h3ff : (c == 1) ? 10'h000 : r[9:0];
         wr(MA, 8'h01); @(posedge CLK_IN); chk(BUSY_OUT, 32'h1);
         wait_irq(2000, n); rng(n + 1, 85 * dv, 87 * dv + 6);
         chk(CHANNEL_OUT, 32'h3);
         bus(1'b0, MA, 8'h00, q); chk(q[7:6], 32'h2);
         bus(1'b0, MA, 8'h00, q); chk(q[7], 32'h0);
         bus(1'b0, RL, 8'h00, q); chk(q, lo_exp(vin, 1'b1));
         bus(1'b0, RH, 8'h00, q); chk(q, vin[9:2]);
         bus(1'b0, RL, 8'h00, q); chk(q[0], 32'h0);
      end
      wr(CK, 8'h01);
      // Single scan of both groups: order, count and one interrupt.
      for (int g = 3; g < 8; g += 4) begin
         chq.delete(); irqs = 0;
         wr(MB, 8'(8'h80 | g)); wr(MA, 8'h03);
         wait_irq(6000, n); rng(n, 4 * 340, 4 * 354);
         repeat (20) @(posedge CLK_IN);
         chk(irqs, 32'h1); chk(chq.size(), 32'h4);
         for (int i = 0; i < 4; i++) chk(chq[i], g - 3 + i);
         bus(1'b0, MA, 8'h00, q); chk(q[7:6], 32'h2);
      end
      // Restart by start bit part-way through a conversion.
      wr(MB, 8'h87); wr(MA, 8'h01); repeat (100) @(posedge CLK_IN);
      irqs = 0; wr(MA, 8'h01);
      wait_irq(2000, n); rng(n, 340, 354);
      repeat (400) @(posedge CLK_IN); chk(irqs, 32'h1);
      // Trigger fall starts; a second fall while busy is ignored.
      wr(MB, 8'ha7); irqs = 0;
      TRIGGER_N_IN <= 1'b0; repeat (3) @(posedge CLK_IN);
      TRIGGER_N_IN <= 1'b1; repeat (200) @(posedge CLK_IN);
      TRIGGER_N_IN <= 1'b0; repeat (3) @(posedge CLK_IN);
      TRIGGER_N_IN <= 1'b1;
      wait_irq(2000, n); rng(n + 206, 344, 358);
      repeat (400) @(posedge CLK_IN); chk(irqs, 32'h1);
      // Fixed repeat with interval mode 0 and 1, then scan repeat; each
      // run is stopped by clearing repeat.
      wr(MB, 8'h87);
      for (int m = 0; m < 3; m++) begin
         k = (m == 0) ? 1 : 4;
         md = (m == 0) ? 8'h05 : (m == 1) ? 8'h0d : 8'h07;
         wr(MA, md);
         wait_irq(5000, n); rng(n, k * 340, k * 354);
         chk(BUSY_OUT, 32'h1);
         wr(MA, md & 8'hfa); n = 0;
         while (BUSY_OUT !== 1'b0 && n < 2000) begin
            @(posedge CLK_IN);
            n++;
         end
         rng(n, 1, 360);
      end
      print_verdict();
   end
endmodule : tb_adcs_top
`default_nettype wire
